/* File: hw/route_pkg.sv */
// constants for the photodiode routing register bank
// assumes apb with 32-bit data; register index times four is the byte address
package route_pkg;

   localparam int          NUM_PD        = 6;
   localparam int          NUM_MOD       = 3;
   localparam int          NUM_STEP      = 4;
   localparam int          NUM_REG       = 8;
   localparam int          SEL_W         = 2;

   // printed register indices; byte address is index * 4
   localparam logic [9:0]  IDX_STEP0_LO  = 10'h0DC;
   localparam logic [9:0]  IDX_STEP0_HI  = 10'h0DD;
   localparam logic [9:0]  IDX_STEP1_LO  = 10'h0DE;
   localparam logic [9:0]  IDX_STEP1_HI  = 10'h0DF;
   localparam logic [9:0]  IDX_STEP2_LO  = 10'h0E0;
   localparam logic [9:0]  IDX_STEP2_HI  = 10'h0E1;
   localparam logic [9:0]  IDX_STEP3_LO  = 10'h0E2;
   localparam logic [9:0]  IDX_STEP3_HI  = 10'h0E3;
   localparam logic [9:0]  IDX_STATUS    = 10'h0F0;
   localparam logic [9:0]  IDX_LIVE      = 10'h0F1;

   // routing selector codes
   localparam logic [1:0]  SEL_NONE      = 2'h0;
   localparam logic [1:0]  SEL_MOD0      = 2'h1;
   localparam logic [1:0]  SEL_MOD1      = 2'h2;
   localparam logic [1:0]  SEL_MOD2      = 2'h3;

   // field positions
   localparam int          LO_PD_COUNT   = 4;
   localparam int          MASK_LSB      = 4;
   localparam int          MASK_REG      = 3;
   localparam int          STAT_ACTIVE   = 2;
   localparam int          STAT_STEP_LSB = 0;

   // reset values, register order step0 lo .. step3 hi
   localparam logic [7:0]  RST_STEP0_LO  = 8'h66;
   localparam logic [7:0]  RST_STEP0_HI  = 8'h06;
   localparam logic [7:0]  RST_STEP1_LO  = 8'h84;
   localparam logic [7:0]  RST_STEP1_HI  = 8'hF3;
   localparam logic [7:0]  RST_STEP2_LO  = 8'h07;
   localparam logic [7:0]  RST_STEP2_HI  = 8'h00;
   localparam logic [7:0]  RST_STEP3_LO  = 8'h00;
   localparam logic [7:0]  RST_STEP3_HI  = 8'h00;

   // writable bits; reserved bits stay zero
   localparam logic [7:0]  WMASK_FULL    = 8'hFF;
   localparam logic [7:0]  WMASK_LOW4    = 8'h0F;

endpackage

/* File: hw/route_if.sv */
// carries the selected step's routing fields to the step latch
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface route_if;
   logic [5:0][1:0] sel;
   logic            sat_en;
   logic [1:0]      step;
   logic            load;
   logic            run;

   modport src (output sel, output sat_en, output step, output load, output run);
   modport dst (input sel, input sat_en, input step, input load, input run);
endinterface
`default_nettype wire

/* File: hw/route_decode.sv */
// decodes one 2-bit routing selector into three switch enables
// assumes purely combinational use inside the step latch
`timescale 1ns/10ps
`default_nettype none
module route_decode (
   input  wire logic [1:0] sel,
   output logic      [2:0] sw
);
   always_comb begin
      case (sel)
         route_pkg::SEL_NONE: sw = 3'h0;
         route_pkg::SEL_MOD0: sw = 3'h1;
         route_pkg::SEL_MOD1: sw = 3'h2;
         route_pkg::SEL_MOD2: sw = 3'h4;
         default:             sw = 3'h0;
      endcase
   end
endmodule
`default_nettype wire

/* File: hw/step_latch.sv */
// holds the switch matrix for the running sequencer step
// assumes load is a one-cycle pulse from the sequencer at step start
`timescale 1ns/10ps
`default_nettype none
module step_latch (
   input  wire logic            pclk,
   input  wire logic            presetn,
   route_if.dst                 rt,
   output logic      [5:0][2:0] sw_q,
   output logic                 sat_q,
   output logic      [1:0]      step_q,
   output logic                 active_q
);
   typedef struct packed {
      logic [5:0][2:0] sw;
      logic            sat;
      logic [1:0]      step;
      logic            active;
   } latch_state_t;

   latch_state_t    s_q;
   latch_state_t    s_d;
   logic [5:0][2:0] dec;

   genvar g;
   generate
      for (g = 0; g < route_pkg::NUM_PD; g++) begin : g_pd
         route_decode u_dec (
            .sel (rt.sel[g]),
            .sw  (dec[g])
         );
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      if (rt.load) begin
         // fields are frozen here, later writes wait for the next step
         s_d.sw     = dec;
         s_d.sat    = rt.sat_en;
         s_d.step   = rt.step;
         s_d.active = 1'b1;
      end else if (!rt.run) begin
         // open every switch while run is low; with run high the last step's switches hold
         s_d.sw     = '0;
         s_d.sat    = 1'b0;
         s_d.active = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sw_q     = s_q.sw;
   assign sat_q    = s_q.sat;
   assign step_q   = s_q.step;
   assign active_q = s_q.active;
endmodule
`default_nettype wire

/* File: hw/seq_route_regs.sv */
// photodiode-to-modulator routing registers and per-step switch matrix
// assumes an apb master on pclk and a sequencer on the same clock
//
// Summary of operation
// - selector 00 open, 01/10/11 modulators 0/1/2
// - own field per photodiode per step
// - pd0-3 in low register, pd4-5 high
// - step0 reset pd4 mod1, pd5 mod0
// - step1 reset pd1 mod0, pd3 mod1, pd4 mod2
// - step2 reset pd0 mod2, pd1 mod0
// - step1 high bits 7:4 saturation step mask
// - saturation mask resets to all ones
// - step0 reset pd0,pd2 mod1; pd1,pd3 mod0
`timescale 1ns/10ps
`default_nettype none
module seq_route_regs (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic [3:0]      pstrb,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic            step_start,
   input  wire logic [1:0]      step_idx,
   input  wire logic            seq_run,
   output logic      [5:0][2:0] pd_mod_sw,
   output logic                 sat_gain_en,
   output logic      [1:0]      active_step,
   output logic                 step_active
);
   typedef struct packed {
      logic [7:0][7:0] regs;
      logic [31:0]     rdata;
      logic            ready;
      logic            err;
   } bus_state_t;

   localparam logic [7:0][7:0] REG_RST = {
      route_pkg::RST_STEP3_HI, route_pkg::RST_STEP3_LO,
      route_pkg::RST_STEP2_HI, route_pkg::RST_STEP2_LO,
      route_pkg::RST_STEP1_HI, route_pkg::RST_STEP1_LO,
      route_pkg::RST_STEP0_HI, route_pkg::RST_STEP0_LO
   };

   // reserved upper nibbles of the step0, step2 and step3 high registers
   localparam logic [7:0][7:0] REG_WMASK = {
      route_pkg::WMASK_LOW4, route_pkg::WMASK_FULL,
      route_pkg::WMASK_LOW4, route_pkg::WMASK_FULL,
      route_pkg::WMASK_FULL, route_pkg::WMASK_FULL,
      route_pkg::WMASK_LOW4, route_pkg::WMASK_FULL
   };

   bus_state_t      s_q;
   bus_state_t      s_d;
   logic [9:0]      word;
   logic [9:0]      roff;
   logic            reg_hit;
   logic            stat_hit;
   logic            live_hit;
   logic            aligned;
   logic            setup_ph;
   logic            access_done;
   logic [2:0]      rsel;
   logic [7:0]      lo_reg;
   logic [7:0]      hi_reg;
   logic [5:0][2:0] sw_q;
   logic            sat_q;
   logic [1:0]      step_q;
   logic            active_q;
   logic [5:0][1:0] live_sel;

   route_if rt ();

   // address decode
   assign word     = paddr[11:2];
   assign roff     = word - route_pkg::IDX_STEP0_LO;
   assign aligned  = (paddr[1:0] == 2'h0);
   assign reg_hit  = aligned && (word >= route_pkg::IDX_STEP0_LO)
                     && (word <= route_pkg::IDX_STEP3_HI);
   assign stat_hit = aligned && (word == route_pkg::IDX_STATUS);
   assign live_hit = aligned && (word == route_pkg::IDX_LIVE);
   assign rsel     = roff[2:0];

   assign setup_ph    = psel && !penable;
   assign access_done = psel && penable && s_q.ready;

   // fields of the step the sequencer is about to start
   assign lo_reg = s_q.regs[{step_idx, 1'b0}];
   assign hi_reg = s_q.regs[{step_idx, 1'b1}];

   genvar g;
   generate
      for (g = 0; g < route_pkg::NUM_PD; g++) begin : g_sel
         if (g < route_pkg::LO_PD_COUNT) begin : g_lo
            assign rt.sel[g] = lo_reg[2*g +: 2];
         end else begin : g_hi
            assign rt.sel[g] = hi_reg[2*(g-route_pkg::LO_PD_COUNT) +: 2];
         end
      end
   endgenerate

   // mask bit 4 is step 0, bit 7 is step 3
   assign rt.sat_en = s_q.regs[route_pkg::MASK_REG][route_pkg::MASK_LSB + step_idx];
   assign rt.step   = step_idx;
   assign rt.load   = step_start && seq_run;
   assign rt.run    = seq_run;

   step_latch u_latch (
      .pclk     (pclk),
      .presetn  (presetn),
      .rt       (rt.dst),
      .sw_q     (sw_q),
      .sat_q    (sat_q),
      .step_q   (step_q),
      .active_q (active_q)
   );

   // live matrix read back as selector codes
   always_comb begin
      for (int i = 0; i < route_pkg::NUM_PD; i++) begin
         case (sw_q[i])
            3'h1:    live_sel[i] = route_pkg::SEL_MOD0;
            3'h2:    live_sel[i] = route_pkg::SEL_MOD1;
            3'h4:    live_sel[i] = route_pkg::SEL_MOD2;
            default: live_sel[i] = route_pkg::SEL_NONE;
         endcase
      end
   end

   always_comb begin
      s_d = s_q;
      if (setup_ph) begin
         // answer is prepared in setup so pready and prdata leave flops
         s_d.ready = 1'b1;
         s_d.err   = !(reg_hit || stat_hit || live_hit);
         s_d.rdata = 32'h0000_0000;
         if (!pwrite) begin
            if (reg_hit) begin
               s_d.rdata[7:0] = s_q.regs[rsel];
            end else if (stat_hit) begin
               s_d.rdata[route_pkg::STAT_ACTIVE]          = active_q;
               s_d.rdata[route_pkg::STAT_STEP_LSB +: 2]   = step_q;
            end else if (live_hit) begin
               s_d.rdata[11:0] = live_sel;
            end
         end
      end else if (access_done) begin
         s_d.ready = 1'b0;
         s_d.err   = 1'b0;
         // only byte lane 0 carries register data
         if (pwrite && reg_hit && pstrb[0]) begin
            s_d.regs[rsel] = pwdata[7:0] & REG_WMASK[rsel];
         end
      end else begin
         s_d.ready = 1'b0;
         s_d.err   = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.regs  <= REG_RST;
         s_q.rdata <= 32'h0000_0000;
         s_q.ready <= 1'b0;
         s_q.err   <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata      = s_q.rdata;
   assign pready      = s_q.ready;
   assign pslverr     = s_q.err;
   assign pd_mod_sw   = sw_q;
   assign sat_gain_en = sat_q;
   assign active_step = step_q;
   assign step_active = active_q;
endmodule
`default_nettype wire

/* File: testbench/seq_route_regs_asserts.sv */
// port checker for the routing register bank
// assumes it is bound onto seq_route_regs
`timescale 1ns/10ps
`default_nettype none
module seq_route_regs_asserts (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic            step_start,
   input wire logic [1:0]      step_idx,
   input wire logic            seq_run,
   input wire logic [5:0][2:0] pd_mod_sw,
   input wire logic            sat_gain_en,
   input wire logic [1:0]      active_step,
   input wire logic            step_active
);
   logic [5:0] oh;
   always_comb for (int p = 0; p < 6; p++) oh[p] = $onehot0(pd_mod_sw[p]);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_start_latch: assert property (step_start && seq_run |=> step_active &&
      active_step == $past(step_idx)) else $error("step start not latched");
   a_one_modulator: assert property (&oh) else $error("pd on two modulators");
   a_hold_step: assert property (!step_start && seq_run |=>
      $stable(pd_mod_sw) && $stable(sat_gain_en)) else $error("matrix moved mid step");
   a_idle_clear: assert property (!step_start && !seq_run |=> !step_active &&
      !sat_gain_en && pd_mod_sw == '0) else $error("idle matrix not cleared");
   a_idle_off: assert property (!step_active |-> pd_mod_sw == '0)
      else $error("switch closed with no step");
   a_rsvd_zero: assert property (pready && !pwrite && paddr == 12'h374 |->
      prdata[31:4] == 28'h0) else $error("reserved bits not zero");
   a_upper_zero: assert property (pready && !pwrite && paddr[11:2] <= 10'h0E3 |->
      prdata[31:8] == 24'h0) else $error("upper read bits not zero");
   a_bad_align: assert property (psel && !penable && paddr[1:0] != 2'h0 |=>
      pready && pslverr && prdata == 32'h0) else $error("unaligned not refused");
endmodule
bind seq_route_regs seq_route_regs_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .step_start(step_start), .step_idx(step_idx),
   .seq_run(seq_run), .pd_mod_sw(pd_mod_sw), .sat_gain_en(sat_gain_en),
   .active_step(active_step), .step_active(step_active));
`default_nettype wire

/* File: testbench/seq_route_regs_bench.sv */
// self-checking bench for the routing register bank
// assumes the port checker binds itself from its own file
`timescale 1ns/10ps
`default_nettype none
module seq_route_regs_bench;
   typedef struct packed { logic [11:0] a; logic [7:0] rst; logic [7:0] wm; } row_t;
   logic            pclk = 1'b0;
   logic            presetn = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [11:0]     paddr = 12'h000;
   logic [31:0]     pwdata = 32'h0;
   logic [3:0]      pstrb = 4'hF;
   logic            step_start = 1'b0;
   logic [1:0]      step_idx = 2'h0;
   logic            seq_run = 1'b0;
   logic [31:0]     prdata, rd;
   logic            pready, pslverr, sat_gain_en, step_active, er;
   logic [5:0][2:0] pd_mod_sw;
   logic [1:0]      active_step;
   int              err_total = 0;
   int              checks = 0;
   // address, reset value, writable bits
   row_t rows [5] = '{'{12'h370, 8'h66, 8'hFF}, '{12'h374, 8'h06, 8'h0F},
      '{12'h378, 8'h84, 8'hFF}, '{12'h37C, 8'hF3, 8'hFF}, '{12'h380, 8'h07, 8'hFF}};
   always #4 pclk = ~pclk;
   seq_route_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .step_start(step_start), .step_idx(step_idx),
      .seq_run(seq_run), .pd_mod_sw(pd_mod_sw), .sat_gain_en(sat_gain_en),
      .active_step(active_step), .step_active(step_active));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // entered just after a rising edge; back-to-back calls are legal
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         err_total++;
         stop_test();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         pstrb <= 4'hF;
         // one idle edge, so the next setup never reassigns psel in this step
         @(posedge pclk);
      end
   endtask
   function automatic logic [2:0] dec(input logic [1:0] c);
      return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
   endfunction
   task automatic run_step(input logic [1:0] s, input logic [7:0] lo, hi, input logic m);
      logic [5:0][2:0] e;
      for (int p = 0; p < 6; p++) e[p] = dec(p < 4 ? lo[2*p +: 2] : hi[2*(p-4) +: 2]);
      step_start <= 1'b1; step_idx <= s; seq_run <= 1'b1;
      @(posedge pclk);
      step_start <= 1'b0;
      @(negedge pclk);
      cmp(pd_mod_sw, e);
      cmp({sat_gain_en, active_step}, {m, s});
      @(posedge pclk);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, rows[i].a, 32'h0);
         cmp(rd, rows[i].rst);
      end
      run_step(2'h0, 8'h66, 8'h06, 1'b1);
      run_step(2'h1, 8'h84, 8'hF3, 1'b1);
      run_step(2'h2, 8'h07, route_pkg::RST_STEP2_HI, 1'b1);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b1, rows[i].a, 32'hFFFFFFFF);
         xfer(1'b0, rows[i].a, 32'h0);
         cmp(rd, rows[i].wm);
      end
      xfer(1'b1, 12'h388, 32'h000000E4);
      xfer(1'b1, 12'h37C, 32'h00000053);
      run_step(2'h3, 8'hE4, 8'h00, 1'b0);
      run_step(2'h0, 8'hFF, 8'h0F, 1'b1);
      // write lands mid step, must wait for the next start
      xfer(1'b1, 12'h370, 32'h0);
      cmp(pd_mod_sw, {6{3'h4}});
      run_step(2'h0, 8'h00, 8'h0F, 1'b1);
      pstrb <= 4'hE;
      xfer(1'b1, 12'h370, 32'h55);
      xfer(1'b0, 12'h371, 32'h0);
      cmp({er, rd}, {1'b1, 32'h0});
      xfer(1'b0, 12'h370, 32'h0);
      cmp({er, rd}, 33'h0);
      run_step(2'h1, 8'hFF, 8'h53, 1'b0);
      presetn <= 1'b0;
      @(negedge pclk);
      cmp({step_active, pd_mod_sw}, 19'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, 12'h37C, 32'h0);
      cmp(rd, 32'hF3);
      seq_run <= 1'b0;
      stop_test();
   end
endmodule
`default_nettype wire
